// File: nvac_pkg.sv
// Operation
// - store holds 128 or 256 bytes
// - byte-wide access, registers in io space
// - program time counted on 8 MHz oscillator
// - atomic mode erases then programs, longest
// - split mode: separate erase and write steps
// - mode bits select started operation
// - host waits for busy clear before starting
// - ready request needs its enable bit
// - host waits idle, then loads address
// - read strobe fetches byte, stalls four cycles
// - host takes fetched byte from data register
// - erase: mode, address, arm, strobe within four
// - write: mode, address, data, arm, strobe
// - program start stalls cpu two cycles
// - busy bit spans operation, blocks mode writes, start and read
// - write-only needs previously erased byte
// - mode codes 00 atomic, 01 erase, 10 write
// - arm clears after four; strobe needs arm
// - mode writes ignored while busy
// - ready request when idle and both enables
package nvac_pkg;
   // ----------------------------------------
   // io register map
   // ----------------------------------------
   localparam logic [5:0] A_CTRL    = 6'h1c;
   localparam logic [5:0] A_DATA    = 6'h1d;
   localparam logic [5:0] A_ADDR_LO = 6'h1e;
   localparam logic [5:0] A_ADDR_HI = 6'h1f;
   localparam int B_RE  = 0;
   localparam int B_PE  = 1;
   localparam int B_ARM = 2;
   localparam int B_RIE = 3;
   localparam int B_MLO = 4;
   localparam int B_MHI = 5;
   typedef enum logic [1:0] {
      M_ATOMIC = 2'b00,
      M_ERASE  = 2'b01,
      M_WRITE  = 2'b10,
      M_RSVD   = 2'b11
   } nvac_mode_t;
   localparam logic [1:0] MODE_RST = 2'b00;
   localparam logic [7:0] ERASED   = 8'hff;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_KHZ      = 250000;
   localparam int OSC_KHZ      = 8000;
   localparam int T_ATOMIC_US  = 3400;
   localparam int T_SPLIT_US   = 1800;
   localparam int ATOMIC_TICKS = T_ATOMIC_US * OSC_KHZ / 1000;
   localparam int SPLIT_TICKS  = T_SPLIT_US * OSC_KHZ / 1000;
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam logic [2:0] RD_STALL   = 3'h4;
   localparam logic [2:0] PG_STALL   = 3'h2;
   // ----------------------------------------
   // host command registers
   // ----------------------------------------
   localparam logic [1:0] H_CMD  = 2'h0;
   localparam logic [1:0] H_ADDR = 2'h1;
   localparam logic [1:0] H_DATA = 2'h2;
   localparam logic [1:0] H_CFG  = 2'h3;
   localparam logic [1:0] OP_READ = 2'h3;
endpackage

// File: nvac_if.sv
interface nvac_if;
   logic [5:0] io_addr;
   logic [7:0] io_wdata;
   logic       io_we;
   logic       io_re;
   logic [7:0] io_rdata;
   logic       stall;
   logic       irq;
   logic       gie;
   modport dev (
      input  io_addr,
      input  io_wdata,
      input  io_we,
      input  io_re,
      input  gie,
      output io_rdata,
      output stall,
      output irq
   );
   modport cpu (
      output io_addr,
      output io_wdata,
      output io_we,
      output io_re,
      output gie,
      input  io_rdata,
      input  stall,
      input  irq
   );
endinterface

// File: nvac_prog_timer.sv
module nvac_prog_timer
   import nvac_pkg::*;
#(
   parameter int TICK_W = 16
) (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              start_i,
   input  wire logic [TICK_W-1:0] ticks_i,
   output logic                   busy_o,
   output logic                   done_o
);
   // ----------------------------------------
   // oscillator tick, phase accumulator
   // ----------------------------------------
   localparam logic [17:0] INC = 18'(OSC_KHZ);
   localparam logic [17:0] TOP = 18'(CLK_KHZ);
   logic [17:0]       acc;
   logic              tick;
   logic [TICK_W-1:0] cnt;

   // average rate exact, jitter one clk per tick
   assign tick = (acc + INC) >= TOP;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) acc <= 18'h0;
      else if (tick) acc <= acc + INC - TOP;
      else acc <= acc + INC;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) cnt <= '0;
      else if (start_i && cnt == '0) cnt <= ticks_i;
      else if (tick && cnt != '0) cnt <= cnt - 1'b1;
   end

   assign busy_o = cnt != '0;
   assign done_o = tick && cnt == TICK_W'(1);
endmodule

// File: nvac_device.sv
module nvac_device
   import nvac_pkg::*;
#(
   parameter int NV_BYTES   = 128,
   parameter int ATOM_TICKS = ATOMIC_TICKS,
   parameter int SPLT_TICKS = SPLIT_TICKS
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   nvac_if.dev       bus
);
   localparam int AW = $clog2(NV_BYTES);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]    store [NV_BYTES];
   logic [AW-1:0] addr;
   logic [7:0]    data;
   nvac_mode_t    mode;
   logic          rie;
   logic [2:0]    arm_cnt;
   logic [2:0]    stall_cnt;
   logic [7:0]    rdata;
   nvac_mode_t    op_mode;
   logic [AW-1:0] op_addr;
   logic [7:0]    op_data;
   logic          pe;
   logic          done;
   logic          wr_ok;
   logic          rd_ok;
   logic          ctrl_wr;
   logic          arm;
   logic          start;
   logic          read_go;
   logic [15:0]   ticks;

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   // a halted cpu issues nothing; drop anything seen anyway
   assign wr_ok   = bus.io_we && stall_cnt == 3'h0;
   assign rd_ok   = bus.io_re && stall_cnt == 3'h0;
   assign ctrl_wr = wr_ok && bus.io_addr == A_CTRL;
   assign arm     = arm_cnt != 3'h0;

   // mode taken from the register as it stands before this write
   assign start = ctrl_wr && bus.io_wdata[B_PE]
                  && arm && !pe
                  && mode != M_RSVD;

   assign read_go = ctrl_wr && bus.io_wdata[B_RE] && !pe;

   assign ticks = (mode == M_ATOMIC) ? 16'(ATOM_TICKS)
                                     : 16'(SPLT_TICKS);

   // ----------------------------------------
   // programming timer
   // ----------------------------------------
   nvac_prog_timer #(
      .TICK_W (16)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .start_i (start),
      .ticks_i (ticks),
      .busy_o  (pe),
      .done_o  (done)
   );

   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode <= M_ATOMIC;
      end else if (ctrl_wr && !pe) begin
         mode <= nvac_mode_t'(bus.io_wdata[B_MHI:B_MLO]);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rie <= 1'b0;
      else if (ctrl_wr) rie <= bus.io_wdata[B_RIE];
   end

   // arm window: visible four cycles, then self-clears
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         arm_cnt <= 3'h0;
      end else if (ctrl_wr && bus.io_wdata[B_ARM]) begin
         arm_cnt <= ARM_CYCLES;
      end else if (arm) begin
         arm_cnt <= arm_cnt - 3'h1;
      end
   end

   // ----------------------------------------
   // cpu halt
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stall_cnt <= 3'h0;
      end else if (read_go) begin
         stall_cnt <= RD_STALL;
      end else if (start) begin
         stall_cnt <= PG_STALL;
      end else if (stall_cnt != 3'h0) begin
         stall_cnt <= stall_cnt - 3'h1;
      end
   end

   assign bus.stall = stall_cnt != 3'h0;

   // ----------------------------------------
   // address and data registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr <= '0;
      end else if (wr_ok && bus.io_addr == A_ADDR_LO) begin
         addr <= bus.io_wdata[AW-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data <= 8'h0;
      end else if (read_go) begin
         data <= store[addr];
      end else if (wr_ok && bus.io_addr == A_DATA) begin
         data <= bus.io_wdata;
      end
   end

   // ----------------------------------------
   // operation latch
   // ----------------------------------------
   // later register writes cannot disturb a running operation
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_mode <= M_ATOMIC;
         op_addr <= '0;
         op_data <= 8'h0;
      end else if (start) begin
         op_mode <= mode;
         op_addr <= addr;
         op_data <= data;
      end
   end

   // ----------------------------------------
   // store update at completion
   // ----------------------------------------
   // not reset: contents are nonvolatile.
   // write-only can only clear bits, so an unerased byte
   // ends up as the and of old and new value
   always_ff @(posedge clk_i) begin
      if (done) begin
         case (op_mode)
            M_ATOMIC: store[op_addr] <= op_data;
            M_ERASE:  store[op_addr] <= ERASED;
            M_WRITE:  store[op_addr] <= store[op_addr] & op_data;
            default:  store[op_addr] <= store[op_addr];
         endcase
      end
   end

   // ----------------------------------------
   // read-back, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata <= 8'h0;
      end else if (rd_ok) begin
         case (bus.io_addr)
            A_CTRL:    rdata <= {2'b00, mode, rie, arm, pe, 1'b0};
            A_DATA:    rdata <= data;
            A_ADDR_LO: rdata <= 8'(addr);
            default:   rdata <= 8'h0;
         endcase
      end else begin
         rdata <= 8'h0;
      end
   end

   assign bus.io_rdata = rdata;

   // ----------------------------------------
   // ready request
   // ----------------------------------------
   // level request: holds as long as the store is idle
   assign bus.irq = rie && bus.gie && !pe;
endmodule

// File: nvac_host.sv
module nvac_host
   import nvac_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic [1:0] sw_addr_i,
   input  wire logic [7:0] sw_wdata_i,
   input  wire logic       sw_we_i,
   input  wire logic       sw_re_i,
   output logic [7:0]      sw_rdata_o,
   nvac_if.cpu             bus
);
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0,
      S_POLL  = 4'h1,
      S_CHK   = 4'h2,
      S_MODE  = 4'h3,
      S_ADDR  = 4'h4,
      S_DATA  = 4'h5,
      S_ARM   = 4'h6,
      S_PE    = 4'h7,
      S_RE    = 4'h8,
      S_RDATA = 4'h9,
      S_CAP   = 4'ha
   } nvac_hst_t;

   nvac_hst_t  state;
   logic [1:0] op;
   logic [7:0] addr;
   logic [7:0] data;
   logic       irq_en;
   logic [7:0] sw_rdata;
   logic [7:0] ctl;

   assign ctl = {2'b00, (op == OP_READ) ? 2'b00 : op, irq_en, 3'b000};

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= S_IDLE;
      end else if (!bus.stall) begin
         case (state)
            S_IDLE:  state <= (sw_we_i && sw_addr_i == H_CMD) ? S_POLL : S_IDLE;
            S_POLL:  state <= S_CHK;
            S_CHK:   state <= bus.io_rdata[B_PE] ? S_POLL
                             : (op == OP_READ) ? S_ADDR : S_MODE;
            S_MODE:  state <= S_ADDR;
            S_ADDR:  state <= (op == OP_READ) ? S_RE : S_DATA;
            S_DATA:  state <= S_ARM;
            S_ARM:   state <= S_PE;
            S_PE:    state <= S_IDLE;
            S_RE:    state <= S_RDATA;
            S_RDATA: state <= S_CAP;
            S_CAP:   state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // io strobes
   // ----------------------------------------
   // nothing is issued while the device halts the cpu
   always_comb begin
      bus.io_we    = 1'b0;
      bus.io_re    = 1'b0;
      bus.io_addr  = A_CTRL;
      bus.io_wdata = 8'h0;
      if (!bus.stall) begin
         case (state)
            S_POLL:  bus.io_re = 1'b1;
            S_MODE:  begin bus.io_we = 1'b1; bus.io_wdata = ctl; end
            S_ADDR:  begin bus.io_we = 1'b1; bus.io_addr = A_ADDR_LO; bus.io_wdata = addr; end
            S_DATA:  begin bus.io_we = 1'b1; bus.io_addr = A_DATA; bus.io_wdata = data; end
            S_ARM:   begin bus.io_we = 1'b1; bus.io_wdata = ctl | 8'h04; end
            S_PE:    begin bus.io_we = 1'b1; bus.io_wdata = ctl | 8'h02; end
            S_RE:    begin bus.io_we = 1'b1; bus.io_wdata = ctl | 8'h01; end
            S_RDATA: begin bus.io_re = 1'b1; bus.io_addr = A_DATA; end
            default: bus.io_we = 1'b0;
         endcase
      end
   end

   assign bus.gie = irq_en;

   // ----------------------------------------
   // command registers
   // ----------------------------------------
   // erasing first is software's job when it picks write-only
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op     <= OP_READ;
         addr   <= 8'h0;
         irq_en <= 1'b0;
      end else if (sw_we_i && state == S_IDLE) begin
         case (sw_addr_i)
            H_CMD:   op <= sw_wdata_i[1:0];
            H_ADDR:  addr <= sw_wdata_i;
            H_CFG:   irq_en <= sw_wdata_i[0];
            default: op <= op;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) data <= 8'h0;
      else if (state == S_CAP) data <= bus.io_rdata;
      else if (sw_we_i && state == S_IDLE && sw_addr_i == H_DATA) data <= sw_wdata_i;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sw_rdata <= 8'h0;
      end else if (sw_re_i) begin
         case (sw_addr_i)
            H_CMD:   sw_rdata <= {6'h0, op};
            H_ADDR:  sw_rdata <= addr;
            H_DATA:  sw_rdata <= data;
            default: sw_rdata <= {5'h0, bus.irq, irq_en, state != S_IDLE};
         endcase
      end else begin
         sw_rdata <= 8'h0;
      end
   end

   assign sw_rdata_o = sw_rdata;
endmodule

// File: nvac_monitor.sv
module nvac_monitor
   import nvac_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_we,
   input wire logic       io_re,
   input wire logic [7:0] io_rdata,
   input wire logic       stall,
   input wire logic       irq,
   input wire logic       gie
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------
   // cpu halt timing
   // ----------------------------------------
   rd_stall_a: assert property (
      io_we && !stall && io_addr == A_CTRL && io_wdata[B_RE] |=> stall [*4] ##1 !stall)
      else $error("read halt length wrong");
   // checked only for a strobe right behind an arm write
   pg_stall_a: assert property (
      io_we && !stall && io_addr == A_CTRL && io_wdata[B_PE] && io_wdata[5:4] != 2'b11
      && $past(io_we && io_addr == A_CTRL && io_wdata[B_ARM]) |=> stall [*2] ##1 !stall)
      else $error("program halt length wrong");
   stall_len_a: assert property ($rose(stall) |-> ##[2:4] $fell(stall))
      else $error("halt outside two to four cycles");
   stall_src_a: assert property ($rose(stall) |-> $past(io_we && io_addr == A_CTRL))
      else $error("halt without control write");

   // ----------------------------------------
   // ready request and read data
   // ----------------------------------------
   busy_irq_a: assert property (
      io_we && !stall && io_addr == A_CTRL && io_wdata[B_PE] && io_wdata[5:4] != 2'b11
      && $past(io_we && io_addr == A_CTRL && io_wdata[B_ARM]) |=> !irq [*8])
      else $error("ready request during programming");
   irq_gie_a: assert property (irq |-> gie)
      else $error("ready request without global enable");
   rdata_idle_a: assert property (!$past(io_re) |-> io_rdata == 8'h00)
      else $error("read data outside answer cycle");
   ctrl_rsv_a: assert property (
      $past(io_re && io_addr == A_CTRL) |-> io_rdata[7:6] == 2'b00 && !io_rdata[B_RE])
      else $error("control reserved bits not zero");
   one_strobe_a: assert property (!(io_we && io_re))
      else $error("read and write strobe together");
endmodule

// File: eeprom_byte_access_controller_bench.sv
module eeprom_byte_access_controller_bench
   import nvac_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   // shortened programming counts keep the run small
   localparam int AT = 8;
   localparam int ST = 4;
   logic       clk_i      = 1'b0;
   logic       rst_b_i    = 1'b0;
   logic [1:0] sw_addr_i  = 2'h0;
   logic [7:0] sw_wdata_i = 8'h00;
   logic       sw_we_i    = 1'b0;
   logic       sw_re_i    = 1'b0;
   logic [7:0] sw_rdata_o;
   int         error_cnt  = 0;
   int         cmp_count  = 0;
   int         cyc        = 0;
   int         st_cnt     = 0;
   int         st_last    = 0;
   nvac_if bus_a ();
   nvac_if bus_b ();

   always #2 clk_i = ~clk_i;

   nvac_host u_nvac_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
      .sw_we_i(sw_we_i), .sw_re_i(sw_re_i), .sw_rdata_o(sw_rdata_o), .bus(bus_a.cpu));
   nvac_device #(.ATOM_TICKS(AT), .SPLT_TICKS(ST)) u_nvac_device (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .bus(bus_a.dev));
   // second device driven directly, to break the host's own sequence
   nvac_device #(.ATOM_TICKS(AT), .SPLT_TICKS(ST)) u_nvac_device_b (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .bus(bus_b.dev));
   nvac_monitor u_nvac_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr(bus_a.io_addr),
      .io_wdata(bus_a.io_wdata), .io_we(bus_a.io_we), .io_re(bus_a.io_re), .io_rdata(bus_a.io_rdata),
      .stall(bus_a.stall), .irq(bus_a.irq), .gie(bus_a.gie));

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      st_cnt <= bus_b.stall ? st_cnt + 1 : 0;
      if (!bus_b.stall && st_cnt != 0) begin
         st_last <= st_cnt;
      end
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int n, input int lo, input int hi);
      cmp_count++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, n, lo, hi);
      end
   endtask

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic h_wr(input logic [1:0] a, input logic [7:0] d);
      sw_addr_i <= a;
      sw_wdata_i <= d;
      sw_we_i <= 1'b1;
      @(posedge clk_i);
      sw_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic h_rd(input logic [1:0] a, output logic [7:0] d);
      sw_addr_i <= a;
      sw_re_i <= 1'b1;
      @(posedge clk_i);
      sw_re_i <= 1'b0;
      #1 d = sw_rdata_o;
      @(posedge clk_i);
   endtask

   task automatic h_idle();
      logic [7:0] r;
      r = 8'h01;
      for (int n = 0; n < 500 && r[0] !== 1'b0; n++) begin
         h_rd(H_CFG, r);
      end
      chk8({7'h00, r[0]}, 8'h00);
   endtask

   // program, then read back; the read waits out the device's busy time
   task automatic h_op(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input int t);
      logic [7:0] r;
      int         t0;
      t0 = cyc;
      h_wr(H_ADDR, a);
      h_wr(H_DATA, d);
      h_wr(H_CMD, {6'h00, m});
      h_idle();
      h_wr(H_CMD, {6'h00, OP_READ});
      h_idle();
      h_rd(H_DATA, r);
      chk8(r, exp);
      chk_rng(cyc - t0, (t - 1) * 31, t * 32 + 60);
   endtask

   task automatic d_wr(input logic [5:0] a, input logic [7:0] d);
      bus_b.io_addr <= a;
      bus_b.io_wdata <= d;
      bus_b.io_we <= 1'b1;
      @(posedge clk_i);
      bus_b.io_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic d_rd(input logic [5:0] a, output logic [7:0] d);
      bus_b.io_addr <= a;
      bus_b.io_re <= 1'b1;
      @(posedge clk_i);
      bus_b.io_re <= 1'b0;
      #1 d = bus_b.io_rdata;
      @(posedge clk_i);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_atomic();
      h_op(M_ATOMIC, 8'h7f, 8'h3c, 8'h3c, AT);
   endtask

   task automatic t_split();
      h_op(M_ERASE, 8'h00, 8'h77, 8'hff, ST);
      h_op(M_WRITE, 8'h00, 8'h5a, 8'h5a, ST);
      h_op(M_WRITE, 8'h00, 8'ha5, 8'h00, ST);
   endtask

   task automatic t_irq();
      logic [7:0] r;
      h_wr(H_CFG, 8'h01);
      h_rd(H_CFG, r);
      // enable bit reaches the device only with the next control write
      chk8(r, 8'h02);
      h_wr(H_CMD, {6'h00, M_ATOMIC});
      h_idle();
      h_rd(H_CFG, r);
      chk8(r, 8'h02);
      h_wr(H_CMD, {6'h00, OP_READ});
      h_idle();
      h_rd(H_CFG, r);
      chk8(r, 8'h06);
      h_wr(H_CFG, 8'h00);
      h_rd(H_CFG, r);
      chk8(r, 8'h00);
   endtask

   task automatic t_refuse();
      logic [7:0] r;
      d_wr(A_CTRL, 8'h02);
      d_rd(A_CTRL, r);
      chk8(r, 8'h00);
      d_wr(A_CTRL, 8'h04);
      repeat (4) @(posedge clk_i);
      d_wr(A_CTRL, 8'h02);
      d_rd(A_CTRL, r);
      chk8(r, 8'h00);
      d_wr(A_CTRL, 8'h34);
      d_wr(A_CTRL, 8'h32);
      repeat (4) @(posedge clk_i);
      d_rd(A_CTRL, r);
      chk8(r, 8'h30);
      d_wr(A_ADDR_LO, 8'h90);
      d_rd(A_ADDR_LO, r);
      chk8(r, 8'h10);
   endtask

   task automatic t_busy();
      logic [7:0] r;
      int         n;
      d_wr(A_DATA, 8'h99);
      d_wr(A_CTRL, 8'h00);
      d_wr(A_CTRL, 8'h04);
      d_wr(A_CTRL, 8'h02);
      repeat (4) @(posedge clk_i);
      #1 chk_rng(st_last, 2, 2);
      d_wr(A_CTRL, 8'h10);
      d_rd(A_CTRL, r);
      chk8(r, 8'h02);
      d_wr(A_CTRL, 8'h01);
      d_rd(A_DATA, r);
      chk8(r, 8'h99);
      for (n = 0; n < 300 && r !== 8'h00; n++) begin
         d_rd(A_CTRL, r);
      end
      chk8(r, 8'h00);
      chk_rng(2 * n, (AT - 1) * 31 - 16, AT * 32);
      d_wr(A_DATA, 8'h00);
      d_wr(A_CTRL, 8'h01);
      repeat (6) @(posedge clk_i);
      #1 chk_rng(st_last, 4, 4);
      d_rd(A_DATA, r);
      chk8(r, 8'h99);
      d_wr(A_CTRL, 8'h20);
      d_rd(A_CTRL, r);
      chk8(r, 8'h20);
   endtask

   initial begin
      bus_b.io_addr = 6'h00;
      bus_b.io_wdata = 8'h00;
      bus_b.io_we = 1'b0;
      bus_b.io_re = 1'b0;
      bus_b.gie = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_atomic();
      t_split();
      t_irq();
      t_refuse();
      t_busy();
      print_verdict();
   end
endmodule
